// [core/tmc_memory_map.sv]
`timescale 1ns/1ps
// What this block does
// R1: answer serial-id space at address A0h
// R2: id bytes 0-95 need password
// R3: id bytes 96-127 vendor storage
// R4: id bytes 128-255 need password
// R5: thresholds 00h-27h writable only with password
// R6: calibration 38h-5Bh writable only with password
// R7: checksum 5Fh writable only with password
// R8: reserved bytes not written, read undefined
// R9: bytes 60h-69h show live analog data
// R10: rate byte bits 7:6 pick rate source
// R11: alarm flags 70h-71h are read-only
// R12: warning flags 74h-75h are read-only
// R13: password at 78h or 7Bh per config
// R14: scratchpad 80h-F7h writable without password
// R15: alarm mask bit one suppresses alarm
// R16: warning mask bit one suppresses warning
// R17: FFh bits drive reset output when enabled
// R18: code 111 gives 125 us low pulse
// R19: clear FFh bits 22.5 ms after pulse
// R20: refuse transactions during nonvolatile write time
// R21: unauthorised protected writes change nothing
// R22: read-only writes acknowledged, no effect
module tmc_memory_map import tmc_pkg::*; #(
   parameter int NVWR_CYC = TMC_NVWR_CYC,
   parameter int CLR_CYC = TMC_CLR_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // byte access from the serial engine
   input wire tmc_req_s req_i,
   input wire logic stop_i,
   output wire logic [7:0] rdata_o,
   output wire logic ack_o,
   output wire logic nack_o,
   // monitoring inputs
   input wire logic [9:0][7:0] analog_i,
   input wire logic [15:0] alarm_i,
   input wire logic [15:0] warn_i,
   // vendor configuration
   input wire logic [31:0] vendor_pw_set_i,
   input wire logic [7:0] vendor_config5,
   input wire logic [7:0] vendor_config3,
   // rate-select pins and outputs
   input wire logic rate_select_pin0,
   input wire logic rate_select_pin1,
   output wire logic [1:0] rate_sel_o,
   output wire logic alarm_o,
   output wire logic warn_o,
   output wire logic general_reset_output
);
   tmc_map_s st_r; // all state
   tmc_map_s st_nxt; // next state
   logic hit; // access aimed at us
   logic is_diag; // diagnostic space selected
   logic is_id; // serial-id space selected
   logic wr_ok; // write that is accepted while not busy
   logic pw_ok; // password matches
   logic [7:0] pw_base; // first password byte
   logic [1:0] soft_rate; // software rate bits
   logic [15:0] amask; // alarm mask word
   logic [15:0] wmask; // warning mask word
   logic gpo_hi; // reset output from sequencer
   logic ctl_clr; // clear request from sequencer
   tmc_kind_e kind; // class of the addressed byte

   // class of a diagnostic byte
   function automatic tmc_kind_e diag_kind(input logic [7:0] a);
      if (a <= TMC_THR_LAST || (a >= TMC_CAL_FIRST && a <= TMC_CAL_LAST) || a == TMC_CKSUM) begin
         return TMC_K_PROT;
      end
      if ((a >= TMC_ANALOG && a <= TMC_ANALOG_LAST) || a == TMC_ALARM ||
          a == TMC_ALARM_LAST || a == TMC_WARN || a == TMC_WARN_LAST) begin
         return TMC_K_LIVE;
      end
      if (a == TMC_CTL || a == TMC_RATE || a == TMC_EXT || a == TMC_USR ||
          (a >= TMC_PW && a <= TMC_PW_LAST) || (a >= TMC_SCR_FIRST && a <= TMC_WMASK_LAST)) begin
         return TMC_K_FREE;
      end
      if (a == TMC_RSTOUT) begin
         return TMC_K_RSTCTL;
      end
      return TMC_K_RSVD;
   endfunction

   // byte that feeds nonvolatile memory
   function automatic logic is_nv(input logic diag, input logic [7:0] a);
      return !diag || diag_kind(a) == TMC_K_PROT || (a >= TMC_SCR_FIRST && a <= TMC_SCR_LAST);
   endfunction

   // address decode and password compare
   always_comb begin
      is_id = {req_i.dev[7:1], 1'b0} == TMC_DEV_ID; // R1
      is_diag = {req_i.dev[7:1], 1'b0} == TMC_DEV_DIAG;
      hit = (req_i.we || req_i.re) && (is_id || is_diag);
      kind = diag_kind(req_i.addr);
      // password window moves with config bit
      pw_base = vendor_config5[TMC_CFG5_PWSEL_BIT] ? TMC_PW_ALT : TMC_PW; // R13
      pw_ok = {st_r.dg[pw_base], st_r.dg[pw_base + 8'h01], st_r.dg[pw_base + 8'h02],
               st_r.dg[pw_base + 8'h03]} == vendor_pw_set_i; // R13
      wr_ok = hit && req_i.we && st_r.busy == 19'h00000;
      soft_rate = {st_r.dg[TMC_EXT][TMC_SOFT_RATE_BIT], st_r.dg[TMC_CTL][TMC_SOFT_RATE_BIT]};
      amask = {st_r.dg[TMC_AMASK], st_r.dg[TMC_AMASK + 8'h01]};
      wmask = {st_r.dg[TMC_WMASK], st_r.dg[TMC_WMASK_LAST]};
   end

   // next-state logic
   always_comb begin
      st_nxt = st_r;
      st_nxt.ack = 1'b0;
      st_nxt.nack = 1'b0;
      // two-flop pin synchroniser
      st_nxt.rs_s1 = {rate_select_pin1, rate_select_pin0};
      st_nxt.rs_s2 = st_r.rs_s1;
      // rate source select
      case (st_r.dg[TMC_RATE][7:6])
         TMC_RM_PINS: begin
            st_nxt.rate = st_r.rs_s2; // R10
         end
         TMC_RM_SOFT: begin
            st_nxt.rate = soft_rate; // R10
         end
         TMC_RM_OR: begin
            st_nxt.rate = st_r.rs_s2 | soft_rate; // R10
         end
         TMC_RM_AND: begin
            st_nxt.rate = st_r.rs_s2 & soft_rate; // R10
         end
         default: begin
            st_nxt.rate = st_r.rs_s2;
         end
      endcase
      // masked summary outputs
      st_nxt.al = |(alarm_i & ~amask); // R15
      st_nxt.wn = |(warn_i & ~wmask); // R16
      // nonvolatile write time counts down
      if (st_r.busy != 19'h00000) begin
         st_nxt.busy = st_r.busy - 19'h00001;
      end
      // stop after a stored write starts the write time
      if (stop_i && st_r.pend && st_r.busy == 19'h00000) begin
         st_nxt.busy = 19'(NVWR_CYC); // R20
         st_nxt.pend = 1'b0;
      end
      // hardware clear of reset control, host write wins below
      if (ctl_clr) begin
         st_nxt.dg[TMC_RSTOUT][2:0] = 3'h0; // R19
      end
      if (hit && st_r.busy != 19'h00000) begin
         // refused while memory is busy
         st_nxt.nack = 1'b1; // R20
      end else if (hit) begin
         st_nxt.ack = 1'b1; // R22
         if (req_i.we && is_id) begin
            // serial-id space
            if (pw_ok || (req_i.addr >= TMC_ID_VEND_FIRST && req_i.addr <= TMC_ID_VEND_LAST)) begin
               st_nxt.idm[req_i.addr] = req_i.wdata; // R2 R3 R4 R21
               st_nxt.pend = 1'b1;
            end
         end else if (req_i.we) begin
            // diagnostic space
            case (kind)
               TMC_K_PROT: begin
                  if (pw_ok) begin
                     st_nxt.dg[req_i.addr] = req_i.wdata; // R5 R6 R7 R21
                     st_nxt.pend = 1'b1;
                  end
               end
               TMC_K_FREE: begin
                  st_nxt.dg[req_i.addr] = req_i.wdata; // R14
                  st_nxt.pend = st_r.pend | is_nv(1'b1, req_i.addr);
               end
               TMC_K_RSTCTL: begin
                  st_nxt.dg[req_i.addr] = req_i.wdata; // R17
               end
               default: begin
                  // live and reserved bytes keep their value
                  st_nxt.dg[req_i.addr] = st_r.dg[req_i.addr]; // R8 R11 R12 R22
               end
            endcase
         end
         if (req_i.re && is_id) begin
            st_nxt.rdata = st_r.idm[req_i.addr];
         end else if (req_i.re && kind == TMC_K_LIVE) begin
            // live values bypass storage
            if (req_i.addr <= TMC_ANALOG_LAST) begin
               st_nxt.rdata = analog_i[4'(TMC_ANALOG_LAST - req_i.addr)]; // R9
            end else if (req_i.addr == TMC_ALARM) begin
               st_nxt.rdata = alarm_i[15:8]; // R11
            end else if (req_i.addr == TMC_ALARM_LAST) begin
               st_nxt.rdata = alarm_i[7:0]; // R11
            end else if (req_i.addr == TMC_WARN) begin
               st_nxt.rdata = warn_i[15:8]; // R12
            end else begin
               st_nxt.rdata = warn_i[7:0]; // R12
            end
         end else if (req_i.re) begin
            st_nxt.rdata = st_r.dg[req_i.addr];
         end
      end
   end

   // state register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         st_r <= TMC_MAP_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // reset-output sequencer
   tmc_rst_pulse #(
      .CLR_CYC(CLR_CYC)
   ) u_rst_pulse (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .en(vendor_config3[TMC_CFG3_RSTEN_BIT]),
      .ctl(st_r.dg[TMC_RSTOUT][2:0]),
      .out_hi(gpo_hi),
      .clr(ctl_clr)
   );

   // outputs straight from flops
   assign rdata_o = st_r.rdata;
   assign ack_o = st_r.ack;
   assign nack_o = st_r.nack;
   assign rate_sel_o = st_r.rate;
   assign alarm_o = st_r.al;
   assign warn_o = st_r.wn;
   assign general_reset_output = gpo_hi;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   AST_BUSY_NACK: assert property (hit && st_r.busy != 19'h00000 |=> nack_o && !ack_o) // R20
      else $error("access during write time not refused");
   AST_PW_GATE: assert property (wr_ok && is_diag && kind == TMC_K_PROT && !pw_ok
                                 |-> st_nxt.dg[req_i.addr] == st_r.dg[req_i.addr]) // R21
      else $error("protected byte changed without password");
   AST_RO_KEEP: assert property (wr_ok && is_diag && kind == TMC_K_LIVE
                                 |-> st_nxt.dg[req_i.addr] == st_r.dg[req_i.addr] ##1 ack_o) // R22
      else $error("read-only write mishandled");
   AST_ANALOG: assert property (hit && req_i.re && is_diag && req_i.addr == TMC_ANALOG &&
                                st_r.busy == 19'h00000 |-> st_nxt.rdata == analog_i[9]) // R9
      else $error("analog byte not live");
   AST_AMASK: assert property (alarm_i[0] && !amask[0] |-> st_nxt.al ##1 alarm_o) // R15
      else $error("unmasked alarm lost");
   AST_WMASK: assert property (wmask == 16'hFFFF |-> !st_nxt.wn) // R16
      else $error("masked warning seen");
   AST_RATE: assert property (st_r.dg[TMC_RATE][7:6] == TMC_RM_SOFT |=> rate_sel_o == $past(soft_rate)) // R10
      else $error("software rate bits not used");
   AST_SCRATCH: assert property (wr_ok && is_diag && req_i.addr == TMC_SCR_FIRST
                                 |-> st_nxt.dg[TMC_SCR_FIRST] == req_i.wdata) // R14
      else $error("scratchpad write lost");
endmodule // tmc_memory_map

// [common/tmc_pkg.sv]
package tmc_pkg;
   // clock and time figures
   localparam int TMC_CLK_NS = 40;
   localparam int TMC_NVWR_NS = 13_000_000;
   localparam int TMC_PULSE_NS = 125_000;
   localparam int TMC_CLR_NS = 22_500_000;
   localparam int TMC_NVWR_CYC = TMC_NVWR_NS / TMC_CLK_NS;
   localparam int TMC_PULSE_CYC = TMC_PULSE_NS / TMC_CLK_NS;
   localparam int TMC_CLR_CYC = TMC_CLR_NS / TMC_CLK_NS;
   // serial device addresses, read/write bit cleared
   localparam logic [7:0] TMC_DEV_ID = 8'hA0;
   localparam logic [7:0] TMC_DEV_DIAG = 8'hA2;
   // serial-id space layout
   localparam logic [7:0] TMC_ID_VEND_FIRST = 8'h60;
   localparam logic [7:0] TMC_ID_VEND_LAST = 8'h7F;
   // diagnostic space layout
   localparam logic [7:0] TMC_THR_LAST = 8'h27;
   localparam logic [7:0] TMC_CAL_FIRST = 8'h38;
   localparam logic [7:0] TMC_CAL_LAST = 8'h5B;
   localparam logic [7:0] TMC_CKSUM = 8'h5F;
   localparam logic [7:0] TMC_ANALOG = 8'h60;
   localparam logic [7:0] TMC_ANALOG_LAST = 8'h69;
   localparam logic [7:0] TMC_CTL = 8'h6E;
   localparam logic [7:0] TMC_RATE = 8'h6F;
   localparam logic [7:0] TMC_ALARM = 8'h70;
   localparam logic [7:0] TMC_ALARM_LAST = 8'h71;
   localparam logic [7:0] TMC_WARN = 8'h74;
   localparam logic [7:0] TMC_WARN_LAST = 8'h75;
   localparam logic [7:0] TMC_EXT = 8'h76;
   localparam logic [7:0] TMC_PW = 8'h78;
   localparam logic [7:0] TMC_PW_ALT = 8'h7B;
   localparam logic [7:0] TMC_PW_LAST = 8'h7E;
   localparam logic [7:0] TMC_SCR_FIRST = 8'h80;
   localparam logic [7:0] TMC_SCR_LAST = 8'hF7;
   localparam logic [7:0] TMC_AMASK = 8'hF8;
   localparam logic [7:0] TMC_WMASK = 8'hFA;
   localparam logic [7:0] TMC_WMASK_LAST = 8'hFB;
   localparam logic [7:0] TMC_USR = 8'hFE;
   localparam logic [7:0] TMC_RSTOUT = 8'hFF;
   // bit positions and the all-ones reset-control code
   localparam int TMC_CFG5_PWSEL_BIT = 2;
   localparam int TMC_CFG3_RSTEN_BIT = 7;
   localparam int TMC_SOFT_RATE_BIT = 3;
   localparam logic [2:0] TMC_RST_CTL_ALL = 3'h7;
   // rate-select modes, bits 7:6 of the rate byte
   localparam logic [1:0] TMC_RM_PINS = 2'h0;
   localparam logic [1:0] TMC_RM_SOFT = 2'h1;
   localparam logic [1:0] TMC_RM_OR = 2'h2;
   localparam logic [1:0] TMC_RM_AND = 2'h3;
   // one byte access from the serial engine
   typedef struct packed {
      logic [7:0] dev;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic we;
      logic re;
   } tmc_req_s;
   typedef enum logic [2:0] {TMC_K_PROT, TMC_K_FREE, TMC_K_LIVE, TMC_K_RSVD, TMC_K_RSTCTL} tmc_kind_e;
   typedef enum logic [1:0] {TMC_P_IDLE, TMC_P_LOW, TMC_P_WAIT} tmc_pstate_e;
   typedef struct packed {
      tmc_pstate_e st;
      logic [19:0] cnt;
      logic out_hi;
      logic clr;
   } tmc_pulse_s;
   localparam tmc_pulse_s TMC_PULSE_RST = '{st: TMC_P_IDLE, cnt: 20'h00000, out_hi: 1'b1,
                                            clr: 1'b0};
   typedef struct packed {
      logic [255:0][7:0] idm;
      logic [255:0][7:0] dg;
      logic [1:0] rs_s1;
      logic [1:0] rs_s2;
      logic [7:0] rdata;
      logic ack;
      logic nack;
      logic [18:0] busy;
      logic pend;
      logic [1:0] rate;
      logic al;
      logic wn;
   } tmc_map_s;
   localparam tmc_map_s TMC_MAP_RST = '0;
endpackage

// [core/tmc_rst_pulse.sv]
`timescale 1ns/1ps
module tmc_rst_pulse import tmc_pkg::*; #(
   parameter int CLR_CYC = TMC_CLR_CYC
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // control
   input wire logic en,
   input wire logic [2:0] ctl,
   // results
   output wire logic out_hi,
   output wire logic clr
);
   tmc_pulse_s s_r; // all state
   tmc_pulse_s s_nxt; // next state
   logic [19:0] lowcnt_r; // helper: low cycles seen
   logic [19:0] hicnt_r; // helper: high cycles seen

   // pulse sequencer
   always_comb begin
      s_nxt = s_r;
      s_nxt.clr = 1'b0;
      case (s_r.st)
         TMC_P_IDLE: begin
            // start a low pulse on the all-ones code
            s_nxt.out_hi = 1'b1;
            // bits still read 111 in the cycle the clear is applied: no restart then
            if (en && ctl == TMC_RST_CTL_ALL && !s_r.clr) begin
               s_nxt.st = TMC_P_LOW; // R18
               s_nxt.out_hi = 1'b0;
               s_nxt.cnt = 20'h00000;
            end
         end
         TMC_P_LOW: begin
            // hold low for the pulse width
            s_nxt.cnt = s_r.cnt + 20'h00001;
            if (s_r.cnt == 20'(TMC_PULSE_CYC - 1)) begin
               s_nxt.st = TMC_P_WAIT; // R18
               s_nxt.out_hi = 1'b1;
               s_nxt.cnt = 20'h00000;
            end
         end
         TMC_P_WAIT: begin
            // wait, then ask for the control bits to clear
            s_nxt.cnt = s_r.cnt + 20'h00001;
            if (s_r.cnt == 20'(CLR_CYC - 1)) begin
               s_nxt.st = TMC_P_IDLE;
               s_nxt.clr = 1'b1; // R19
            end
         end
         default: begin
            s_nxt = TMC_PULSE_RST;
         end
      endcase
      // output only follows the bits while the mode is on
      if (!en) begin
         s_nxt = TMC_PULSE_RST; // R17
      end
   end

   // state register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         s_r <= TMC_PULSE_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // helper counters for checks
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         lowcnt_r <= 20'h00000;
         hicnt_r <= 20'h00000;
      end else begin
         lowcnt_r <= s_r.out_hi ? 20'h00000 : lowcnt_r + 20'h00001;
         hicnt_r <= s_r.out_hi ? hicnt_r + 20'h00001 : 20'h00000;
      end
   end

   assign out_hi = s_r.out_hi;
   assign clr = s_r.clr;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   AST_RST_OFF: assert property (!en |=> out_hi) // R17
      else $error("reset output low while mode disabled");
   AST_PULSE_LEN: assert property ($rose(out_hi) && en && $past(en) |-> lowcnt_r == TMC_PULSE_CYC) // R18
      else $error("reset pulse width wrong");
   AST_CLR_GAP: assert property (clr |-> hicnt_r == CLR_CYC && out_hi) // R19
      else $error("control clear at wrong time");
   AST_CLR_IDLE: assert property (clr |=> out_hi) // R19
      else $error("reset pulse restarted by the clear");
endmodule // tmc_rst_pulse

// [bench/tmc_host_model.sv]
`timescale 1ns/1ps
// host side of the byte-access port: one request, then a wait for its answer
module tmc_host_model import tmc_pkg::*; (
   // clock
   input wire logic core_clk,
   // answer from the map
   input wire logic [7:0] rdata_o,
   input wire logic ack_o,
   input wire logic nack_o,
   // request to the map
   output tmc_req_s req_i,
   output logic stop_i
);
   // idle bus at time zero
   initial begin
      req_i = '0;
      stop_i = 1'b0;
   end

   // one byte access, repeated while the map is busy, up to 100 tries; the address is passed through unchecked, reserved bytes included
   task automatic xfer(input logic [7:0] dev, input logic [7:0] addr, input logic [7:0] wd,
                       input logic w, output logic [7:0] rd, output logic ok, output int tries);
      begin
         tries = 0;
         do begin
            @(posedge core_clk);
            req_i <= '{dev, addr, wd, w, !w};
            @(posedge core_clk);
            req_i.we <= 1'b0;
            req_i.re <= 1'b0;
            #1;
            ok = ack_o;
            rd = rdata_o;
            tries++;
         end while (nack_o === 1'b1 && tries < 100);
      end
   endtask

   // stop condition, one cycle
   task automatic stop();
      begin
         @(posedge core_clk);
         stop_i <= 1'b1;
         @(posedge core_clk);
         stop_i <= 1'b0;
      end
   endtask
endmodule // tmc_host_model

// [bench/testbench.sv]
`timescale 1ns/1ps
module testbench import tmc_pkg::*;;
   // shortened write time and clear delay
   localparam int NV = 20;
   localparam int CL = 40;
   // one table row: access and expected readback
   typedef struct packed {
      logic [7:0] dev;
      logic [7:0] addr;
      logic [7:0] wd;
      logic w;
      logic [7:0] exp;
   } tmc_row_s;
   localparam tmc_row_s ROWS [12] = '{
      '{8'hA2, 8'h80, 8'h5A, 1'b1, 8'h5A}, '{8'hA2, 8'h00, 8'h33, 1'b1, 8'h00},
      '{8'hA2, 8'h38, 8'h33, 1'b1, 8'h00}, '{8'hA2, 8'h5F, 8'h33, 1'b1, 8'h00},
      '{8'hA2, 8'h70, 8'hFF, 1'b1, 8'hC3}, '{8'hA2, 8'h74, 8'hFF, 1'b1, 8'h96},
      '{8'hA2, 8'h60, 8'hFF, 1'b1, 8'hA9}, '{8'hA2, 8'h69, 8'h00, 1'b0, 8'h90},
      '{8'hA2, 8'h28, 8'h00, 1'b0, 8'h00}, '{8'hA0, 8'h60, 8'h77, 1'b1, 8'h77},
      '{8'hA0, 8'h00, 8'h77, 1'b1, 8'h00}, '{8'hA0, 8'h80, 8'h77, 1'b1, 8'h00}};
   // rate result per mode with pins 10 and soft bits 01
   localparam logic [1:0] RATE_EXP [4] = '{2'h2, 2'h1, 2'h3, 2'h0};
   // clock, reset and design inputs
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   tmc_req_s req;
   logic stop;
   logic [9:0][7:0] analog_i = '0;
   logic [15:0] alarm_i = 16'hC301;
   logic [15:0] warn_i = 16'h9600;
   logic [31:0] pw_set = 32'h11223344;
   logic [7:0] cfg5 = 8'h00;
   logic [7:0] cfg3 = 8'h00;
   logic pin0 = 1'b0;
   logic pin1 = 1'b1;
   // design outputs
   logic [7:0] rdata_o;
   logic ack_o, nack_o, alarm_o, warn_o, general_reset_output;
   logic [1:0] rate_sel_o;
   // bookkeeping
   int err_count = 0;
   int checks = 0;
   logic [7:0] rd;
   logic ok;
   int n;

   always #20 core_clk = ~core_clk;

   tmc_memory_map #(.NVWR_CYC(NV), .CLR_CYC(CL)) i_tmc_memory_map (
      .core_clk(core_clk), .rst_n(rst_n), .req_i(req), .stop_i(stop), .rdata_o(rdata_o),
      .ack_o(ack_o), .nack_o(nack_o), .analog_i(analog_i), .alarm_i(alarm_i), .warn_i(warn_i),
      .vendor_pw_set_i(pw_set), .vendor_config5(cfg5), .vendor_config3(cfg3),
      .rate_select_pin0(pin0), .rate_select_pin1(pin1), .rate_sel_o(rate_sel_o),
      .alarm_o(alarm_o), .warn_o(warn_o), .general_reset_output(general_reset_output));

   tmc_host_model i_tmc_host_model (
      .core_clk(core_clk), .rdata_o(rdata_o), .ack_o(ack_o), .nack_o(nack_o),
      .req_i(req), .stop_i(stop));

   // compare and count
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // write a byte, read it back, compare
   task automatic wr_rd(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] d,
                        input logic [7:0] exp);
      i_tmc_host_model.xfer(dev, a, d, 1'b1, rd, ok, n);
      i_tmc_host_model.xfer(dev, a, 8'h00, 1'b0, rd, ok, n);
      check({8'h00, rd}, {8'h00, exp});
   endtask

   // verdict
   task automatic end_of_test();
      $display("errors %0d checks %0d", err_count, checks);
      if (err_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // watchdog
   initial begin
      repeat (20000) @(posedge core_clk);
      err_count++;
      end_of_test();
   end

   initial begin
      analog_i[9] = 8'hA9;
      analog_i[0] = 8'h90;
      repeat (6) @(posedge core_clk);
      rst_n <= 1'b1;
      #1;
      // reset state of the outputs
      check({rdata_o, ack_o, nack_o, general_reset_output, rate_sel_o, alarm_o, warn_o, 1'b0},
            16'h0020);
      // table of plain accesses
      foreach (ROWS[i]) begin
         i_tmc_host_model.xfer(ROWS[i].dev, ROWS[i].addr, ROWS[i].wd, ROWS[i].w, rd, ok, n);
         check({15'h0, ok}, 16'h0001);
         i_tmc_host_model.xfer(ROWS[i].dev, ROWS[i].addr, 8'h00, 1'b0, rd, ok, n);
         check({8'h00, rd}, {8'h00, ROWS[i].exp});
      end
      // password at the default place unlocks thresholds
      for (int k = 0; k < 4; k++) i_tmc_host_model.xfer(8'hA2, 8'(120 + k), pw_set[31-8*k -: 8],
                                                          1'b1, rd, ok, n);
      wr_rd(8'hA2, 8'h00, 8'h55, 8'h55);
      // alternate place selected: old entry no longer valid
      cfg5 <= 8'h04;
      wr_rd(8'hA2, 8'h38, 8'hAA, 8'h00);
      for (int k = 0; k < 4; k++) i_tmc_host_model.xfer(8'hA2, 8'(123 + k), pw_set[31-8*k -: 8],
                                                          1'b1, rd, ok, n);
      wr_rd(8'hA2, 8'h38, 8'hAA, 8'hAA);
      // masks: all set hides flags, one clear bit lets a set flag through
      wr_rd(8'hA2, 8'hF8, 8'hFF, 8'hFF);
      wr_rd(8'hA2, 8'hF9, 8'hFF, 8'hFF);
      wr_rd(8'hA2, 8'hFA, 8'hFF, 8'hFF);
      wr_rd(8'hA2, 8'hFB, 8'hFF, 8'hFF);
      repeat (3) @(posedge core_clk);
      check({14'h0, alarm_o, warn_o}, 16'h0000);
      wr_rd(8'hA2, 8'hF9, 8'hFE, 8'hFE);
      wr_rd(8'hA2, 8'hFA, 8'h7F, 8'h7F);
      repeat (3) @(posedge core_clk);
      check({14'h0, alarm_o, warn_o}, 16'h0003);
      // every rate-select mode
      wr_rd(8'hA2, TMC_CTL, 8'h08, 8'h08);
      for (int m = 0; m < 4; m++) begin
         wr_rd(8'hA2, TMC_RATE, {2'(m), 6'h00}, {2'(m), 6'h00});
         repeat (6) @(posedge core_clk);
         check({14'h0, rate_sel_o}, {14'h0, RATE_EXP[m]});
      end
      // write time after stop refuses, then lets the host in
      i_tmc_host_model.xfer(8'hA2, 8'h81, 8'h3C, 1'b1, rd, ok, n);
      i_tmc_host_model.stop();
      i_tmc_host_model.xfer(8'hA2, 8'h81, 8'h00, 1'b0, rd, ok, n);
      check({7'h0, n > 1, rd}, 16'h013C);
      // reset output stays high while its mode is off
      wr_rd(8'hA2, TMC_RSTOUT, 8'h07, 8'h07);
      repeat (10) @(posedge core_clk);
      check({15'h0, general_reset_output}, 16'h0001);
      wr_rd(8'hA2, TMC_RSTOUT, 8'h00, 8'h00);
      cfg3 <= 8'h80;
      // pulse length, then late clear of the control bits
      i_tmc_host_model.xfer(8'hA2, TMC_RSTOUT, 8'h07, 1'b1, rd, ok, n);
      n = 0;
      while (general_reset_output !== 1'b0 && n < 10) begin
         @(negedge core_clk);
         n++;
      end
      n = 0;
      while (general_reset_output === 1'b0 && n < 4000) begin
         @(negedge core_clk);
         n++;
      end
      check(n[15:0], 16'(TMC_PULSE_CYC));
      i_tmc_host_model.xfer(8'hA2, TMC_RSTOUT, 8'h00, 1'b0, rd, ok, n);
      check({8'h00, rd}, 16'h0007);
      repeat (CL + 10) @(posedge core_clk);
      i_tmc_host_model.xfer(8'hA2, TMC_RSTOUT, 8'h00, 1'b0, rd, ok, n);
      check({8'h00, rd}, 16'h0000);
      check({15'h0, general_reset_output}, 16'h0001);
      // reset in mid-run: outputs back to idle, stored bytes cleared
      @(posedge core_clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      #1;
      check({rdata_o, ack_o, nack_o, general_reset_output, rate_sel_o, alarm_o, warn_o, 1'b0},
            16'h0020);
      i_tmc_host_model.xfer(8'hA2, 8'h80, 8'h00, 1'b0, rd, ok, n);
      check({8'h00, rd}, 16'h0000);
      end_of_test();
   end
endmodule // testbench
